// File: shared/uart_rx_consts.vh
`ifndef UART_RX_CONSTS_VH
`define UART_RX_CONSTS_VH
// Register byte addresses (word aligned)
`define ADDR_TX_STATUS_CONTROL 8'h00
`define ADDR_RX_STATUS_CONTROL 8'h04
`define ADDR_BAUD_CONTROL 8'h08
`define ADDR_BAUD_DIV_LOW 8'h0C
`define ADDR_BAUD_DIV_HIGH 8'h10
`define ADDR_TX_DATA 8'h14
`define ADDR_RX_DATA 8'h18
`define ADDR_INT_CONTROL 8'h1C
// Transmit status/control fields
`define TXS_NINE_BIT 6
`define TXS_ENABLE 5
`define TXS_SYNC 4
`define TXS_HIGH_RATE 2
`define TXS_SHIFT_EMPTY 1
`define TXS_NINTH 0
// Receive status/control fields
`define RXS_PORT_EN 7
`define RXS_NINE_BIT 6
`define RXS_RX_EN 4
`define RXS_ADDR_DET 3
`define RXS_FRAME_ERR 2
`define RXS_OVERRUN 1
`define RXS_NINTH 0
// Baud control fields
`define BDC_IDLE 6
`define BDC_RX_INV 5
`define BDC_TX_INV 4
`define BDC_WIDE 3
// Interrupt control fields
`define INT_GLOBAL 7
`define INT_PERIPH 6
`define INT_RX_EN 5
`define INT_TX_EN 4
`define INT_RX_FLAG 1
`define INT_TX_FLAG 0
// Writable masks, unimplemented bits read zero
`define TXS_WMASK 8'h75
`define RXS_WMASK 8'hD8
`define BDC_WMASK 8'h38
`define INT_WMASK 8'hF0
// Reset values
`define RESET_TXS 8'h00
`define RESET_RXS 8'h00
`define RESET_BDC 8'h00
// Oversampling ratio and centre point
`define OVERSAMPLE 5'd16
`define HALF_BIT 4'd7
`endif

// File: logic/uart_rx_core.v
`timescale 1ns/1ps
`include "uart_rx_consts.vh"
module uart_rx_core #(
  parameter DEPTH = 2
) (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  // AXI4-Lite write address and data
  input wire [7:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  // AXI4-Lite write response
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  // AXI4-Lite read
  input wire [7:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  // Serial lines
  input wire RX_LINE_I,
  output wire TX_LINE_O,
  output wire TX_LINE_OE_O,
  // Interrupt requests
  output wire RX_IRQ_O,
  output wire TX_IRQ_O
);
  // Control registers
  reg [7:0] txs_q; // Transmit status/control
  reg [7:0] rxs_q; // Receive status/control (writable part)
  reg [7:0] bdc_q; // Baud control
  reg [7:0] div_lo_q; // Baud divisor low
  reg [7:0] div_hi_q; // Baud divisor high
  reg [7:0] intc_q; // Interrupt enables
  reg [8:0] tx_hold_q; // Transmit holding register with ninth bit
  reg tx_hold_full_q; // Holding register occupied
  // Write channel latches, taken in either order
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire port_en = rxs_q[`RXS_PORT_EN];
  wire sync_mode = txs_q[`TXS_SYNC];
  wire rx_active = rxs_q[`RXS_RX_EN] & ~sync_mode & port_en;
  wire tx_active = txs_q[`TXS_ENABLE] & ~sync_mode & port_en;
  // Baud tick generator: divisor width follows the wide select
  reg [15:0] brg_cnt_q;
  wire [15:0] brg_div = bdc_q[`BDC_WIDE] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  wire os_tick = (brg_cnt_q == 16'h0000); // Sixteen ticks per bit
  // Baud counter reloads from the divisor each oversample tick
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !port_en) begin
      brg_cnt_q <= 16'h0000;
    end else if (os_tick) begin
      brg_cnt_q <= brg_div;
    end else begin
      brg_cnt_q <= brg_cnt_q - 16'h0001;
    end
  end
  // Receive path: line is synchronous, polarity applied first
  wire rx_bit = RX_LINE_I ^ bdc_q[`BDC_RX_INV];
  reg rx_prev_q; // Previous line level for edge detect
  reg [2:0] vote_q; // Last three oversamples for majority
  wire vote_maj = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_STOP = 4'b1000;
  reg [3:0] st_q;
  reg [3:0] os_cnt_q; // Oversample position within a bit
  reg [3:0] bit_cnt_q; // Data bits taken
  reg [8:0] shift_q; // Receive shift register
  reg overrun_q; // Overrun flag
  // Receive queue storage
  reg [7:0] q_data_q [0:DEPTH-1];
  reg q_ninth_q [0:DEPTH-1];
  reg q_framing_error_flag_q [0:DEPTH-1];
  reg [1:0] q_count_q;
  reg q_rd_q; // Read pointer
  reg q_wr_q; // Write pointer
  wire nine_rx = rxs_q[`RXS_NINE_BIT];
  wire [3:0] bits_needed = nine_rx ? 4'd9 : 4'd8;
  wire bit_centre = os_tick && (os_cnt_q == 4'hF);
  // Character completes at stop centre
  wire char_done = (st_q == ST_STOP) && bit_centre;
  // Address detect in nine-bit mode drops characters without ninth bit set
  wire char_keep = !(rxs_q[`RXS_ADDR_DET] && nine_rx && !shift_q[8]);
  wire q_full = (q_count_q == DEPTH);
  wire push = char_done && char_keep && !q_full;
  wire rd_data_fire; // Pop request from a data register read
  wire pop = rd_data_fire && (q_count_q != 2'd0);
  // Receive state machine: start detect, verify, sample, stop
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !rx_active) begin
      st_q <= ST_IDLE;
      os_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 9'h000;
      rx_prev_q <= 1'b1;
      vote_q <= 3'b111;
    end else begin
      if (os_tick) begin
        rx_prev_q <= rx_bit;
        vote_q <= {vote_q[1:0], rx_bit};
      end
      case (st_q)
        ST_IDLE: begin
          // Overrun holds the receiver off
          if (os_tick && rx_prev_q && !rx_bit && !overrun_q) begin
            st_q <= ST_START;
            os_cnt_q <= 4'h0;
          end
        end
        ST_START: begin
          if (os_tick) begin
            if (os_cnt_q == `HALF_BIT) begin
              if (rx_bit) begin
                st_q <= ST_IDLE;
              end else begin
                st_q <= ST_DATA;
                bit_cnt_q <= 4'h0;
              end
              os_cnt_q <= 4'h0;
            end else begin
              os_cnt_q <= os_cnt_q + 4'h1;
            end
          end
        end
        ST_DATA: begin
          if (os_tick) begin
            os_cnt_q <= os_cnt_q + 4'h1;
            if (os_cnt_q == 4'hF) begin
              // LSB first: shift right, final bit lands at top
              if (nine_rx) begin
                shift_q <= {vote_maj, shift_q[8:1]};
              end else begin
                shift_q <= {1'b0, vote_maj, shift_q[7:1]};
              end
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q + 4'h1 == bits_needed) begin
                st_q <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (os_tick) begin
            os_cnt_q <= os_cnt_q + 4'h1;
            if (os_cnt_q == 4'hF) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // Queue writes: store character, ninth bit and framing result
  always @(posedge CORE_CLK_I) begin
    if (push) begin
      // Both widths leave the first bit in bit 0, so the low byte is always [7:0]
      q_data_q[q_wr_q] <= shift_q[7:0];
      q_ninth_q[q_wr_q] <= nine_rx & shift_q[8];
      q_framing_error_flag_q[q_wr_q] <= ~vote_maj;
    end
  end
  // Queue pointers; port disable resets the queue, receive disable keeps it
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !port_en) begin
      q_count_q <= 2'd0;
      q_rd_q <= 1'b0;
      q_wr_q <= 1'b0;
    end else begin
      if (push) begin
        q_wr_q <= ~q_wr_q;
      end
      if (pop) begin
        q_rd_q <= ~q_rd_q;
      end
      q_count_q <= q_count_q + {1'b0, push} - {1'b0, pop};
    end
  end
  // Overrun: third kept character with full queue; set beats clear
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      overrun_q <= 1'b0;
    end else if (char_done && char_keep && q_full && !pop) begin
      overrun_q <= 1'b1;
    end else if (!rxs_q[`RXS_RX_EN] || !port_en) begin
      overrun_q <= 1'b0;
    end
  end
  // Head of queue status
  wire head_framing_error_flag = (q_count_q != 2'd0) & q_framing_error_flag_q[q_rd_q];
  wire head_ninth = (q_count_q != 2'd0) & q_ninth_q[q_rd_q];
  wire rx_flag = rx_active && (q_count_q != 2'd0);
  // Transmitter: holding register feeds shifter
  reg [10:0] tsr_q; // Start, data, ninth, stop
  reg [3:0] tx_bits_q; // Bits left to send
  reg [3:0] tx_os_q; // Oversample count per bit
  reg tx_out_q; // Line level before polarity
  wire tsr_empty = (tx_bits_q == 4'h0);
  wire tx_load = tx_active && tx_hold_full_q && tsr_empty;
  wire tx_flag = tx_active && !tx_hold_full_q;
  // Shift register: start bit then data LSB first then stop
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !tx_active) begin
      tsr_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_os_q <= 4'h0;
      tx_out_q <= 1'b1;
    end else if (tx_load) begin
      // Ninth bit marks address in nine-bit mode
      if (txs_q[`TXS_NINE_BIT]) begin
        tsr_q <= {1'b1, tx_hold_q, 1'b0};
        tx_bits_q <= 4'd11;
      end else begin
        tsr_q <= {1'b1, 1'b1, tx_hold_q[7:0], 1'b0};
        tx_bits_q <= 4'd10;
      end
      tx_os_q <= 4'h0;
    end else if (!tsr_empty && os_tick) begin
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == 4'h0) begin
        tx_out_q <= tsr_q[0];
        tsr_q <= {1'b1, tsr_q[10:1]};
      end
      if (tx_os_q == 4'hF) begin
        tx_bits_q <= tx_bits_q - 4'h1;
      end
    end
  end
  assign TX_LINE_O = tx_out_q ^ bdc_q[`BDC_TX_INV];
  assign TX_LINE_OE_O = port_en & ~sync_mode;
  // Interrupt requests
  wire gates = intc_q[`INT_GLOBAL] & intc_q[`INT_PERIPH];
  assign RX_IRQ_O = rx_flag & intc_q[`INT_RX_EN] & gates;
  assign TX_IRQ_O = tx_flag & intc_q[`INT_TX_EN] & gates;
  // AXI4-Lite write side
  assign AWREADY_O = !aw_got_q && !BVALID_O;
  assign WREADY_O = !w_got_q && !BVALID_O;
  wire [7:0] wa = AWVALID_I && AWREADY_O ? AWADDR_I : aw_addr_q;
  wire [31:0] wd = WVALID_I && WREADY_O ? WDATA_I : w_data_q;
  wire [3:0] ws = WVALID_I && WREADY_O ? WSTRB_I : w_strb_q;
  wire aw_have = aw_got_q || (AWVALID_I && AWREADY_O);
  wire w_have = w_got_q || (WVALID_I && WREADY_O);
  wire wr_fire = aw_have && w_have && !BVALID_O;
  wire wr_lane0 = wr_fire && ws[0];
  // Decode of implemented addresses
  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a[1:0] == 2'b00) && (a <= `ADDR_INT_CONTROL);
    end
  endfunction
  // Write latches and response
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'b00;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_addr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_data_q <= WDATA_I;
        w_strb_q <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= addr_known(wa) ? 2'b00 : 2'b10;
      end else begin
        aw_got_q <= aw_have;
        w_got_q <= w_have;
        if (BVALID_O && BREADY_I) begin
          BVALID_O <= 1'b0;
        end
      end
    end
  end

  // Register writes; flags are read-only so masks exclude them
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      txs_q <= `RESET_TXS;
      rxs_q <= `RESET_RXS;
      bdc_q <= `RESET_BDC;
      div_lo_q <= 8'h00;
      div_hi_q <= 8'h00;
      intc_q <= 8'h00;
      tx_hold_q <= 9'h000;
      tx_hold_full_q <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_hold_full_q <= 1'b0;
      end
      if (wr_lane0) begin
        case (wa)
          `ADDR_TX_STATUS_CONTROL: txs_q <= wd[7:0] & `TXS_WMASK;
          `ADDR_RX_STATUS_CONTROL: rxs_q <= wd[7:0] & `RXS_WMASK;
          `ADDR_BAUD_CONTROL: bdc_q <= wd[7:0] & `BDC_WMASK;
          `ADDR_BAUD_DIV_LOW: div_lo_q <= wd[7:0];
          `ADDR_BAUD_DIV_HIGH: div_hi_q <= wd[7:0];
          `ADDR_INT_CONTROL: intc_q <= wd[7:0] & `INT_WMASK;
          `ADDR_TX_DATA: begin
            // Ninth bit taken from control as written earlier
            tx_hold_q <= {txs_q[`TXS_NINTH], wd[7:0]};
            tx_hold_full_q <= tx_active;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // AXI4-Lite read side, one-cycle answer
  assign ARREADY_O = !RVALID_O;
  wire rd_fire = ARVALID_I && ARREADY_O;
  assign rd_data_fire = rd_fire && (ARADDR_I == `ADDR_RX_DATA);

  // Read value assembly; unimplemented bits are zero
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    case (ARADDR_I)
      `ADDR_TX_STATUS_CONTROL: rd_val = txs_q | {6'h00, tsr_empty, 1'b0};
      `ADDR_RX_STATUS_CONTROL:
        rd_val = rxs_q | {5'h00, head_framing_error_flag, overrun_q, head_ninth};
      `ADDR_BAUD_CONTROL: rd_val = bdc_q | {1'b0, (st_q == ST_IDLE), 6'h00};
      `ADDR_BAUD_DIV_LOW: rd_val = div_lo_q;
      `ADDR_BAUD_DIV_HIGH: rd_val = div_hi_q;
      `ADDR_RX_DATA: rd_val = (q_count_q != 2'd0) ? q_data_q[q_rd_q] : 8'h00;
      `ADDR_INT_CONTROL: rd_val = intc_q | {6'h00, rx_flag, tx_flag};
      default: rd_val = 8'h00;
    endcase
  end

  // Read data register and response
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= 2'b00;
    end else if (rd_fire) begin
      RVALID_O <= 1'b1;
      RDATA_O <= {24'h00_0000, rd_val};
      RRESP_O <= addr_known(ARADDR_I) ? 2'b00 : 2'b10;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

endmodule // uart_rx_core

// File: sim/uart_rx_core_sva.sv
`timescale 1ns/1ps
module uart_rx_core_sva #(
  parameter DEPTH = 2
) (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  // Register bus
  input wire [7:0] AWADDR_I,
  input wire AWVALID_I,
  input wire AWREADY_O,
  input wire WVALID_I,
  input wire WREADY_O,
  input wire [1:0] BRESP_O,
  input wire BVALID_O,
  input wire [7:0] ARADDR_I,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire [31:0] RDATA_O,
  input wire [1:0] RRESP_O,
  input wire RVALID_O,
  // Interrupt requests
  input wire RX_IRQ_O,
  input wire TX_IRQ_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // High when no transfer can pop the queue or rewrite an enable
  wire bus_idle;
  assign bus_idle = !(ARVALID_I && ARREADY_O) && !(AWVALID_I && AWREADY_O)
    && !(WVALID_I && WREADY_O);
  // Address and data taken at one edge
  sequence s_wr_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  // Read address taken
  sequence s_rd_take;
    ARVALID_I && ARREADY_O;
  endsequence
  AST_RST_QUIET: assert property (
    $fell(SYS_RST_I) |-> !RX_IRQ_O && !TX_IRQ_O && !BVALID_O && !RVALID_O)
    else $error("outputs active after reset");
  AST_WR_ANSWER: assert property (
    s_wr_take |=> BVALID_O) else $error("write not answered");
  AST_WR_SLVERR: assert property (
    s_wr_take ##0 (AWADDR_I > 8'h1C) |=> BVALID_O && (BRESP_O == 2'b10))
    else $error("unmapped write not refused");
  AST_RD_ANSWER: assert property (
    s_rd_take |=> RVALID_O && (RDATA_O[31:8] == 24'h0))
    else $error("read answer late or upper bits set");
  AST_RD_SLVERR: assert property (
    s_rd_take ##0 (ARADDR_I > 8'h1C) |=> RVALID_O && (RRESP_O == 2'b10))
    else $error("unmapped read not refused");
  AST_AR_BLOCK: assert property (
    RVALID_O |-> !ARREADY_O) else $error("read accepted while answering");
  AST_AW_BLOCK: assert property (
    BVALID_O |-> !AWREADY_O) else $error("write accepted while answering");
  AST_RX_FLAG_STICKY: assert property (
    RX_IRQ_O && bus_idle |=> RX_IRQ_O) else $error("receive request dropped");
endmodule // uart_rx_core_sva

// File: sim/uart_line_peer.sv
`timescale 1ns/1ps
module uart_line_peer #(
  parameter BIT_CLKS = 16
) (
  // Clock and serial lines
  input wire clk_i,
  input wire tx_line_i,
  output logic rx_line_o
);
  logic inv_q = 1'b0; // Line polarity in use
  int bit_clks = BIT_CLKS; // Clocks per bit; the bench follows the divisor here
  initial rx_line_o = 1'b1; // Idle mark
  // Drive one level for n clocks, just after an edge
  task automatic hold(input logic lvl, input int n);
    rx_line_o <= lvl ^ inv_q;
    repeat (n) @(posedge clk_i);
  endtask
  // One character: start, data LSB first, stop, idle gap
  task automatic send_char(input logic [8:0] v, input int nb, input logic stop);
    hold(1'b0, bit_clks);
    for (int i = 0; i < nb; i++) hold(v[i], bit_clks);
    hold(stop, bit_clks);
    hold(1'b1, bit_clks);
  endtask
  // Short low pulse that must not count as a start bit
  task automatic glitch();
    hold(1'b0, 4);
    hold(1'b1, 2 * bit_clks);
  endtask
  // Select low-true or high-true line levels, then idle one bit
  task automatic set_inv(input logic v);
    inv_q = v;
    hold(1'b1, bit_clks);
  endtask
  // Capture one character from the device; unknown on timeout
  task automatic recv_char(output logic [8:0] v);
    int n;
    n = 0;
    v = 9'bx;
    while (tx_line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 4000) begin
      repeat (bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        v[i] = tx_line_i;
      end
    end
  endtask
endmodule // uart_line_peer

// File: sim/async_uart_receiver_tx_setup_tb.sv
`timescale 1ns/1ps
`include "uart_rx_consts.vh"
module async_uart_receiver_tx_setup_tb;
  // Stimulus
  logic CORE_CLK_I, SYS_RST_I, AWVALID_I, WVALID_I, ARVALID_I;
  logic [7:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I;
  // Design outputs, and the receive line driven by the peer
  wire AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, RX_LINE_I;
  wire TX_LINE_O, TX_LINE_OE_O, RX_IRQ_O, TX_IRQ_O;
  wire [1:0] BRESP_O, RRESP_O;
  wire [31:0] RDATA_O;
  int fail_count = 0;
  int checks_done = 0;
  logic [1:0] resp_q; // Last bus response
  logic [31:0] rv; // Last read value
  logic [8:0] cv; // Captured character
  uart_rx_core #(.DEPTH(2)) dut (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
    .WSTRB_I(4'hF), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
    .BVALID_O(BVALID_O), .BREADY_I(1'b1), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
    .RREADY_I(1'b1), .RX_LINE_I(RX_LINE_I), .TX_LINE_O(TX_LINE_O),
    .TX_LINE_OE_O(TX_LINE_OE_O), .RX_IRQ_O(RX_IRQ_O), .TX_IRQ_O(TX_IRQ_O));
  // Far side; divisor 0 gives sixteen clocks a bit
  // Receive pin is a plain digital input here, nothing else shares it
  uart_line_peer #(.BIT_CLKS(16)) peer (.clk_i(CORE_CLK_I), .tx_line_i(TX_LINE_O),
    .rx_line_o(RX_LINE_I));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One edge of a bounded wait; a spent bound ends the run
  task automatic tick(inout int n);
    @(posedge CORE_CLK_I);
    n++;
    if (n > 200) begin
      fail_count++;
      stop_test();
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    AWADDR_I <= a;
    WDATA_I <= {24'h0, d};
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    do begin
      tick(n);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
    end while (!BVALID_O);
    resp_q = BRESP_O;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    do begin
      tick(n);
      if (ARREADY_O) ARVALID_I <= 1'b0;
    end while (!RVALID_O);
    v = RDATA_O;
    resp_q = RRESP_O;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    check(what, rv, e);
  endtask
  // Reset values, read-only and unimplemented bits, unmapped place
  task automatic t_regs();
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'h0);
    check("tx oe", TX_LINE_OE_O, 0);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'h0);
    wr(`ADDR_BAUD_CONTROL, 8'hFF);
    rd(`ADDR_BAUD_CONTROL, rv);
    check("baud ctl", rv & 32'hBF, 32'h38);
    wr(`ADDR_INT_CONTROL, 8'h0F);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'h0);
    wr(`ADDR_BAUD_CONTROL, 8'h00);
    wr(8'h40, 8'h00);
    check("wr resp", resp_q, 2'b10);
    rd(8'h40, rv);
    check("rd resp", resp_q, 2'b10);
  endtask
  // Transmit setup order, flag, interrupt and two characters, eight-bit and nine-bit
  task automatic t_tx();
    wr(`ADDR_BAUD_DIV_LOW, 8'h00);
    wr(`ADDR_BAUD_DIV_HIGH, 8'h00);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(`ADDR_TX_STATUS_CONTROL, 8'h20);
    check("tx oe", TX_LINE_OE_O, 1);
    wr(`ADDR_BAUD_CONTROL, 8'h10);
    check("tx line", TX_LINE_O, 0);
    wr(`ADDR_BAUD_CONTROL, 8'h00);
    check("tx line", TX_LINE_O, 1);
    rchk("tx flag", `ADDR_INT_CONTROL, 32'h01);
    wr(`ADDR_INT_CONTROL, 8'hD0);
    check("tx irq", TX_IRQ_O, 1);
    wr(`ADDR_INT_CONTROL, 8'h50);
    check("tx irq", TX_IRQ_O, 0);
    fork
      wr(`ADDR_TX_DATA, 8'hA5);
      peer.recv_char(cv);
    join
    check("tx char", cv, 9'h1A5);
    // Nine-bit send: ninth bit written first, captured in place of the stop
    wr(`ADDR_TX_STATUS_CONTROL, 8'h61);
    fork
      wr(`ADDR_TX_DATA, 8'h5A);
      peer.recv_char(cv);
    join
    check("tx addr char", cv, 9'h15A);
    wr(`ADDR_TX_STATUS_CONTROL, 8'h20);
  endtask
  // One character received, flag and gated interrupt
  task automatic t_rx();
    wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
    peer.send_char(9'h03C, 8, 1'b1);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'h53);
    wr(`ADDR_INT_CONTROL, 8'hE0);
    check("rx irq", RX_IRQ_O, 1);
    wr(`ADDR_INT_CONTROL, 8'h60);
    check("rx irq", RX_IRQ_O, 0);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'h90);
    rchk("rx data", `ADDR_RX_DATA, 32'h3C);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'h61);
  endtask
  // Two queued, third lost, framing error follows the oldest
  task automatic t_overrun();
    wr(`ADDR_INT_CONTROL, 8'hE0);
    peer.send_char(9'h011, 8, 1'b1);
    peer.send_char(9'h022, 8, 1'b0);
    peer.send_char(9'h033, 8, 1'b1);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'h92);
    rchk("rx data", `ADDR_RX_DATA, 32'h11);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'h96);
    rchk("rx data", `ADDR_RX_DATA, 32'h22);
    check("rx irq", RX_IRQ_O, 0);
    peer.send_char(9'h044, 8, 1'b1);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'hE1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'h90);
    peer.send_char(9'h055, 8, 1'b1);
    rchk("rx data", `ADDR_RX_DATA, 32'h55);
  endtask
  // False start, disabled receiver, sync mode, nine bits, inversion
  task automatic t_misc();
    peer.glitch();
    rchk("int ctl", `ADDR_INT_CONTROL, 32'hE1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    peer.send_char(9'h066, 8, 1'b1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
    wr(`ADDR_TX_STATUS_CONTROL, 8'h30);
    check("tx oe", TX_LINE_OE_O, 0);
    peer.send_char(9'h077, 8, 1'b1);
    wr(`ADDR_TX_STATUS_CONTROL, 8'h20);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'hE1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'hD0);
    peer.send_char(9'h1A5, 9, 1'b1);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'hD1);
    rchk("rx data", `ADDR_RX_DATA, 32'hA5);
    // Receiver off while both ends change polarity, so no false start
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(`ADDR_BAUD_CONTROL, 8'h20);
    peer.set_inv(1'b1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
    peer.send_char(9'h0C3, 8, 1'b1);
    rchk("rx data", `ADDR_RX_DATA, 32'hC3);
  endtask
  // Address detect drops plain characters; high divisor byte unused unless wide
  task automatic t_addr_baud();
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(`ADDR_BAUD_CONTROL, 8'h00);
    peer.set_inv(1'b0);
    wr(`ADDR_RX_STATUS_CONTROL, 8'hD8);
    peer.send_char(9'h012, 9, 1'b1);
    peer.send_char(9'h134, 9, 1'b1);
    rchk("rx ctl", `ADDR_RX_STATUS_CONTROL, 32'hD9);
    rchk("rx data", `ADDR_RX_DATA, 32'h34);
    rchk("int ctl", `ADDR_INT_CONTROL, 32'hE1);
    wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(`ADDR_BAUD_DIV_LOW, 8'h01);
    wr(`ADDR_BAUD_DIV_HIGH, 8'h01);
    peer.bit_clks = 32;
    wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
    peer.send_char(9'h096, 8, 1'b1);
    rchk("rx data", `ADDR_RX_DATA, 32'h96);
  endtask
  initial begin
    CORE_CLK_I = 1'b0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end
  initial begin
    SYS_RST_I = 1'b1;
    AWVALID_I = 1'b0;
    WVALID_I = 1'b0;
    ARVALID_I = 1'b0;
    AWADDR_I = 8'h00;
    ARADDR_I = 8'h00;
    WDATA_I = 32'h0;
    repeat (12) @(posedge CORE_CLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge CORE_CLK_I);
    t_regs();
    t_tx();
    t_rx();
    t_overrun();
    t_misc();
    t_addr_baud();
    stop_test();
  end
endmodule // async_uart_receiver_tx_setup_tb
bind uart_rx_core uart_rx_core_sva #(.DEPTH(DEPTH)) chk (.CORE_CLK_I(CORE_CLK_I),
  .SYS_RST_I(SYS_RST_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
  .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
  .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
  .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RX_IRQ_O(RX_IRQ_O), .TX_IRQ_O(TX_IRQ_O));
